// ==== adc_port_defs.svh ====
// Constants of the converter serial port and data-ready logic
// Operation
// - Accept free-running or gated serial clock
// - Drive inverted master clock copy out
// - Clock-disable bit switches master clock output off
// - Chip select active low gates transfers
// - Chip select tied low gives three-wire port
// - Reset pin restores power-on state
// - Data-ready low when new word available
// - Data-ready high after full word read
// - Unread word: data-ready high before update
// - Data-ready low after each update
// - Data-ready low marks calibration finished
// - Output shift loads selected register
// - Input shift writes selected register
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// -----------------------------------------------------------------
// Communication register layout
// -----------------------------------------------------------------
`define COMM_SEL_MSB    3
`define COMM_SEL_LSB    4
`define COMM_SEL_HI     6
`define COMM_RW_BIT     3
`define SEL_COMM        3'h0
`define SEL_SETUP       3'h1
`define SEL_CLOCK       3'h2
`define SEL_DATA        3'h3

// -----------------------------------------------------------------
// Reset values, field positions and timing
// -----------------------------------------------------------------
`define COMM_RESET      8'h00
`define SETUP_RESET     8'h01
`define CLOCK_RESET     8'h05
`define CLK_DIS_BIT     4
`define BYTE_BITS       5'h08
`define WORD_BITS       5'h10
`define MCLK_EARLY      16'h01f4
`define UPDATE_DEFAULT  16'h1388

`endif

// ==== adc_port_pkg.sv ====
// Types shared by the converter serial port logic
`default_nettype none
`include "adc_port_defs.svh"

package adc_port_pkg;

  // Serial port phase: expect command, write a register, read a register
  typedef enum logic [1:0] {st_comm, st_write, st_read} phase_t;

  // Whole state of the port, registered in one process
  typedef struct packed {
    logic        sclk_s1, sclk_s2, sclk_d;
    logic        cs_s1, cs_s2;
    logic        din_s1, din_s2;
    logic        mclk_s1, mclk_s2, mclk_d;
    logic        rstn_s1, rstn_s2;
    phase_t      phase;
    logic [4:0]  bit_cnt;
    logic [4:0]  len;
    logic [7:0]  in_shift;
    logic [15:0] out_shift;
    logic [7:0]  comm;
    logic [7:0]  setup;
    logic [7:0]  clk_reg;
    logic [15:0] data;
    logic [15:0] rate_cnt;
    logic        ready_n;
    logic        dout;
    logic        mclk_out;
  } port_state_t;

endpackage

`default_nettype wire

// ==== adc_serial_port.sv ====
// Serial port, data-ready flag and master clock output of the converter
`default_nettype none
`include "adc_port_defs.svh"

module adc_serial_port
#(
  parameter logic [15:0] UPDATE_PERIOD = `UPDATE_DEFAULT  // Master clocks per output update
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        reset_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        mclk_in,
  input  wire logic [15:0] conv_data,
  input  wire logic        cal_done,
  output logic             dout,
  output logic             dout_oe,
  output logic             data_ready_n,
  output logic             mclk_out,
  output logic             mclk_out_oe,
  output adc_port_pkg::phase_t port_phase
);
  import adc_port_pkg::*;

  port_state_t s;
  port_state_t next_s;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [4:0] reg_len(input logic [2:0] sel);
    reg_len = (sel == `SEL_DATA) ? `WORD_BITS : `BYTE_BITS;
  endfunction

  // Read value left-aligned so the MSB is always bit 15
  function automatic logic [15:0] reg_value(input port_state_t st, input logic [2:0] sel);
    case (sel)
      `SEL_COMM:  reg_value = {st.comm, 8'h00};
      `SEL_SETUP: reg_value = {st.setup, 8'h00};
      `SEL_CLOCK: reg_value = {st.clk_reg, 8'h00};
      `SEL_DATA:  reg_value = st.data;
      default:    reg_value = 16'h0000;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // Edge events, all from second synchroniser stages
  // -----------------------------------------------------------------
  logic       active;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       mclk_rise;
  logic       early_pt;
  logic       update_pt;
  logic [7:0] byte_in;
  logic [2:0] cur_sel;

  // Edges seen whatever the clock's continuity, so bursts just pause
  assign active    = ~s.cs_s2;
  assign sclk_rise = active & s.sclk_s2 & ~s.sclk_d;
  assign sclk_fall = active & ~s.sclk_s2 & s.sclk_d;
  assign mclk_rise = s.mclk_s2 & ~s.mclk_d;
  assign early_pt  = mclk_rise && (s.rate_cnt == 16'(UPDATE_PERIOD - `MCLK_EARLY - 16'h1));
  assign update_pt = mclk_rise && (s.rate_cnt == 16'(UPDATE_PERIOD - 16'h1));
  assign byte_in   = {s.in_shift[6:0], s.din_s2};
  assign cur_sel   = s.comm[`COMM_SEL_HI:`COMM_SEL_LSB];

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.sclk_s1 = sclk;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_d  = s.sclk_s2;
    next_s.cs_s1   = cs_n;
    next_s.cs_s2   = s.cs_s1;
    next_s.din_s1  = din;
    next_s.din_s2  = s.din_s1;
    next_s.mclk_s1 = mclk_in;
    next_s.mclk_s2 = s.mclk_s1;
    next_s.mclk_d  = s.mclk_s2;
    next_s.rstn_s1 = reset_n;
    next_s.rstn_s2 = s.rstn_s1;

    // Inverted copy of the master clock, three sample clocks late
    next_s.mclk_out = ~s.mclk_s2;

    // Serial shifting; a high chip select freezes bit count mid-byte
    if (sclk_rise)
    begin
      next_s.in_shift = byte_in;
      next_s.bit_cnt  = s.bit_cnt + 5'h01;
      case (s.phase)
        st_comm:
          if (s.bit_cnt == `BYTE_BITS - 5'h01)
          begin
            next_s.comm    = byte_in;
            next_s.bit_cnt = 5'h00;
            if (byte_in[`COMM_RW_BIT])
            begin
              next_s.phase     = st_read;
              next_s.len       = reg_len(byte_in[`COMM_SEL_HI:`COMM_SEL_LSB]);
              next_s.out_shift = reg_value(s, byte_in[`COMM_SEL_HI:`COMM_SEL_LSB]);
            end
            else if (byte_in[`COMM_SEL_HI:`COMM_SEL_LSB] != `SEL_DATA)
            begin
              next_s.phase = st_write;
              next_s.len   = `BYTE_BITS;
            end
          end
        st_write:
          if (s.bit_cnt == s.len - 5'h01)
          begin
            next_s.phase   = st_comm;
            next_s.bit_cnt = 5'h00;
            case (cur_sel)
              `SEL_COMM:  next_s.comm    = byte_in;
              `SEL_SETUP: next_s.setup   = byte_in;
              `SEL_CLOCK: next_s.clk_reg = byte_in;
              default:    next_s.comm    = s.comm;
            endcase
          end
        st_read:
          if (s.bit_cnt == s.len - 5'h01)
          begin
            next_s.phase   = st_comm;
            next_s.bit_cnt = 5'h00;
            if (cur_sel == `SEL_DATA)
              next_s.ready_n = 1'b1;
          end
        default:
          next_s.phase = st_comm;
      endcase
    end
    else if (sclk_fall && s.phase == st_read && s.bit_cnt != 5'h00)
      next_s.out_shift = {s.out_shift[14:0], 1'b0};

    // Update timer counts master clock edges so timing tracks the part's rate
    if (mclk_rise)
      next_s.rate_cnt = update_pt ? 16'h0000 : s.rate_cnt + 16'h0001;
    if (early_pt)
      next_s.ready_n = 1'b1;
    // A new word wins over a read finishing in the same cycle
    if (update_pt)
    begin
      next_s.data    = conv_data;
      next_s.ready_n = 1'b0;
    end
    if (cal_done)
      next_s.ready_n = 1'b0;

    next_s.dout = next_s.out_shift[15];

    // Pin reset restores everything except the synchronisers and the master clock output copy
    if (~s.rstn_s2)
    begin
      next_s.phase     = st_comm;
      next_s.bit_cnt   = 5'h00;
      next_s.len       = `BYTE_BITS;
      next_s.in_shift  = 8'h00;
      next_s.out_shift = 16'h0000;
      next_s.comm      = `COMM_RESET;
      next_s.setup     = `SETUP_RESET;
      next_s.clk_reg   = `CLOCK_RESET;
      next_s.data      = 16'h0000;
      next_s.rate_cnt  = 16'h0000;
      next_s.ready_n   = 1'b1;
      next_s.dout      = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s           <= '0;
      s.sclk_s1   <= 1'b1;  // Parked high: a false fall is harmless, a false rise eats a bit
      s.sclk_s2   <= 1'b1;
      s.sclk_d    <= 1'b1;
      s.cs_s1     <= 1'b1;
      s.cs_s2     <= 1'b1;
      s.rstn_s1   <= 1'b1;
      s.rstn_s2   <= 1'b1;
      s.phase     <= st_comm;
      s.len       <= `BYTE_BITS;
      s.comm      <= `COMM_RESET;
      s.setup     <= `SETUP_RESET;
      s.clk_reg   <= `CLOCK_RESET;
      s.ready_n   <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Output pins; clock-disable parks the master clock output
  assign dout         = s.dout;
  assign dout_oe      = active && s.phase == st_read;
  assign data_ready_n = s.ready_n;
  assign mclk_out     = s.mclk_out & ~s.clk_reg[`CLK_DIS_BIT];
  assign mclk_out_oe  = ~s.clk_reg[`CLK_DIS_BIT];
  assign port_phase   = s.phase;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  ready_update_a: assert property (@(posedge clock) disable iff (rst)
    update_pt && s.rstn_s2 |=> !data_ready_n)
    else $error("data ready not low after update");
  ready_early_a: assert property (@(posedge clock) disable iff (rst)
    early_pt && !cal_done && s.rstn_s2 |=> data_ready_n)
    else $error("data ready not high before update");
  ready_read_a: assert property (@(posedge clock) disable iff (rst)
    sclk_rise && s.phase == st_read && s.bit_cnt == `WORD_BITS - 5'h01
    && cur_sel == `SEL_DATA && !update_pt && !cal_done && s.rstn_s2 |=> data_ready_n)
    else $error("data ready not high after word read");
  mclk_invert_a: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) && mclk_out_oe && $stable(mclk_out_oe) |-> mclk_out == !$past(s.mclk_s2))
    else $error("master clock output not inverted copy");
  mclk_disable_a: assert property (@(posedge clock) disable iff (rst)
    s.clk_reg[`CLK_DIS_BIT] |-> !mclk_out_oe && !mclk_out)
    else $error("master clock output driven while disabled");
  cs_idle_a: assert property (@(posedge clock) disable iff (rst)
    s.cs_s2 && s.cs_s1 && s.rstn_s2 |=> $stable(s.bit_cnt) && !dout_oe)
    else $error("port moved while deselected");
  pin_reset_a: assert property (@(posedge clock) disable iff (rst)
    !s.rstn_s2 |=> s.phase == st_comm && data_ready_n && s.clk_reg == `CLOCK_RESET)
    else $error("pin reset did not restore state");
  cal_ready_a: assert property (@(posedge clock) disable iff (rst)
    cal_done && s.rstn_s2 |=> !data_ready_n)
    else $error("calibration end not flagged");
  read_load_a: assert property (@(posedge clock) disable iff (rst)
    sclk_rise && s.phase == st_comm && s.bit_cnt == 5'h07 && byte_in[`COMM_RW_BIT]
    && byte_in[`COMM_SEL_HI:`COMM_SEL_LSB] == `SEL_SETUP && s.rstn_s2
    |=> s.phase == st_read && dout == s.setup[7] ##0 s.len == `BYTE_BITS)
    else $error("output shift not loaded from setup");
  write_store_a: assert property (@(posedge clock) disable iff (rst)
    sclk_rise && s.phase == st_write && s.bit_cnt == 5'h07 && cur_sel == `SEL_CLOCK
    && s.rstn_s2 |=> s.clk_reg == $past(byte_in) && s.phase == st_comm)
    else $error("clock register write lost");

endmodule // adc_serial_port

`default_nettype wire

// ==== adc_host_model.sv ====
// Host serial port model facing the converter port
`default_nettype none
module adc_host_model
(
  input  wire logic clock,
  input  wire logic dout,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands high between frames; select tied low gives three wires
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b0;
    din  = 1'b0;
  end
  // Select changes only while the clock stands still
  task automatic select(input logic val);
    @(posedge clock);
    cs_n <= val;
    repeat (4) @(posedge clock);
  endtask
  // n bits MSB first, four clocks a half period; one call is one batch
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clock);
      sclk <= 1'b0;
      din  <= tx[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      rx = {rx[14:0], dout};
    end
    // Released data line shows the inverse, not a held bit
    @(posedge clock);
    din <= ~din;
    repeat (8) @(posedge clock);
  endtask
endmodule // adc_host_model
`default_nettype wire

// ==== adc_serial_port_bench.sv ====
// Self-checking bench of the converter serial port and data-ready flag
`default_nettype none
module adc_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_port_pkg::*;
  localparam logic [15:0] PERIOD = 16'h0258;
  logic        clock, rst, reset_n, sclk, cs_n, din, mclk_in, cal_done;
  logic        dout, dout_oe, data_ready_n, mclk_out, mclk_out_oe;
  logic [15:0] conv_data, v;
  logic [2:0]  mcnt;
  phase_t      port_phase;
  int          bad_count, cmp_count;

  adc_serial_port #(.UPDATE_PERIOD(PERIOD)) u_dut
  (
    .clock(clock), .rst(rst), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .mclk_in(mclk_in), .conv_data(conv_data), .cal_done(cal_done), .dout(dout),
    .dout_oe(dout_oe), .data_ready_n(data_ready_n), .mclk_out(mclk_out),
    .mclk_out_oe(mclk_out_oe), .port_phase(port_phase)
  );
  adc_host_model u_host (.clock(clock), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Master clock of 2 MHz, locked to the bench clock so counts are exact
  always @(posedge clock)
  begin
    mcnt <= (mcnt == 3'h4) ? 3'h0 : mcnt + 3'h1;
    if (mcnt == 3'h4)
      mclk_in <= ~mclk_in;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait for a flag level; n returns the clocks spent
  task automatic wait_ready(input logic lvl, output int n);
    n = 0;
    while (data_ready_n !== lvl)
    begin
      @(posedge clock);
      n++;
      if (n > 20000)
      begin
        bad_count++;
        $display("Error at %0t ns: flag wait ran out", $time);
        complete_run();
      end
    end
  endtask
  // Command and data sent as two batches with the clock stopped between
  task automatic wr(input logic [7:0] cmd, input logic [7:0] val);
    u_host.xfer(8, {8'h00, cmd}, v);
    u_host.xfer(8, {8'h00, val}, v);
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] got);
    u_host.xfer(8, {8'h00, cmd}, got);
    u_host.xfer(n, 16'h0000, got);
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic test_reset();
    chk({12'h000, data_ready_n, dout_oe, mclk_out_oe, 1'b0}, 16'h000a);
    chk({14'h0000, port_phase}, {14'h0000, st_comm});
  endtask
  task automatic test_cal();
    cal_done <= 1'b1;
    @(posedge clock);
    cal_done <= 1'b0;
    repeat (3) @(posedge clock);
    chk({15'h0000, data_ready_n}, 16'h0000);
  endtask
  // Gated and free-running writes of the setup register, then readback of the setup and clock registers
  task automatic test_regs();
    wr(8'h10, 8'h5a);
    rd(8'h18, 8, v);
    chk(v, 16'h005a);
    u_host.xfer(16, 16'h10c3, v);
    rd(8'h18, 8, v);
    chk(v, 16'h00c3);
    rd(8'h28, 8, v);
    chk(v, 16'h0005);
  endtask
  // A write sent with select high must leave the register alone
  task automatic test_select();
    u_host.select(1'b1);
    u_host.xfer(16, 16'h10ff, v);
    u_host.select(1'b0);
    rd(8'h18, 8, v);
    chk(v, 16'h00c3);
  endtask
  // Late in each master phase the output must be the inverse
  task automatic test_mclk();
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clock);
      if (mcnt == 3'h4)
        chk({15'h0000, mclk_out}, {15'h0000, ~mclk_in});
    end
    wr(8'h20, 8'h15);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clock);
      chk({14'h0000, mclk_out_oe, mclk_out}, 16'h0000);
    end
  endtask
  task automatic test_read();
    int n;
    conv_data <= 16'hb64d;
    wait_ready(1'b1, n);
    wait_ready(1'b0, n);
    u_host.xfer(8, 16'h0038, v);
    chk({15'h0000, dout_oe}, 16'h0001);
    u_host.xfer(16, 16'h0000, v);
    chk(v, 16'hb64d);
    chk({14'h0000, data_ready_n, dout_oe}, 16'h0002);
  endtask
  // Unread word: the flag stands high 500 master clocks before the update
  task automatic test_early();
    int n;
    wait_ready(1'b0, n);
    wait_ready(1'b1, n);
    wait_ready(1'b0, n);
    chk((n >= 4998 && n <= 5002) ? 16'h0001 : 16'h0000, 16'h0001);
  endtask
  task automatic test_pin_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk({14'h0000, data_ready_n, mclk_out_oe}, 16'h0003);
    rd(8'h18, 8, v);
    chk(v, 16'h0001);
  endtask

  initial
  begin
    rst = 1'b1;
    reset_n = 1'b1;
    mclk_in = 1'b0;
    mcnt = 3'h0;
    conv_data = 16'h0000;
    cal_done = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    test_reset();
    test_cal();
    test_regs();
    test_select();
    test_mclk();
    test_read();
    test_early();
    test_pin_reset();
    complete_run();
  end
endmodule // adc_serial_port_bench
`default_nettype wire
